// ==== design/hlpc_pkg.sv ====
// ============================================================
// shared constants
package hlpc_pkg;
	localparam logic [7:0] HALT_OPCODE = 8'h8E;
	localparam logic [1:0] MASK_ENABLE_ALL = 2'b10;
	localparam logic [1:0] MASK_RESET = 2'b11;
	localparam int unsigned WAIT_SHORT = 256;
	localparam int unsigned WAIT_LONG = 4096;
	localparam int unsigned CNT_W = 13;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OPTION = 8'h08;
	// control fields
	localparam int unsigned CTRL_RTC_IE = 0;
	// option fields
	localparam int unsigned OPT_LONG = 0;
	localparam int unsigned OPT_WDG_HALT = 1;
	localparam logic [2:0] OPTION_RESET = 3'h0;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		ST_RUN,
		ST_ACTIVE_HALT,
		ST_HALT,
		ST_STABILIZE,
		ST_RESET_WAIT
	} hlpc_state_e;
endpackage

// ==== design/hlpc_top.sv ====
`timescale 1ns/1ps
// What this block does
// - halt opcode enters active-halt when rtc_irq_enable is 1, else full halt.
// - active-halt ends only on rtc interrupt, wake-capable interrupt or reset.
// - interrupt exit from active-halt resumes at once without stabilization.
// - reset exit from active-halt waits 256 or 4096 cycles before vector.
// - entering either halt state forces mask level bits to binary 10.
// - active-halt keeps only oscillator and rtc counter clocked.
// - watchdog cannot reset during active-halt while rtc interrupt enabled.
// - clearing rtc enable within delay after wake drops into stabilize for the remaining count.
// - full halt ends only on reset or wake-capable interrupt, not rtc.
// - full halt exit restarts oscillator and waits 256 or 4096 cycles.
// - full halt stops oscillator and all internally clocked peripherals.
// - non-volatile option decides whether watchdog runs through full halt.
// - byte 0x8E is decoded as the halt instruction.
// - servicing wake interrupt pushes condition code and sets priority mask.
module hlpc_top #(
	parameter int unsigned WAIT_SHORT_CYC = hlpc_pkg::WAIT_SHORT,
	parameter int unsigned WAIT_LONG_CYC = hlpc_pkg::WAIT_LONG
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// cpu side
	input wire logic OPCODE_VALID_I,
	input wire logic [7:0] OPCODE_I,
	input wire logic SERVICE_I,
	input wire logic [1:0] ISR_LEVEL_I,
	input wire logic CC_POP_I,
	input wire logic [1:0] CC_POP_MASK_I,
	// wake sources (asynchronous)
	input wire logic RTC_IRQ_I,
	input wire logic WAKE_IRQ_I,
	input wire logic EXT_RESET_I,
	// watchdog
	input wire logic WDG_ENABLED_I,
	input wire logic WDG_EXPIRE_I,
	// axi4-lite slave
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	// outputs
	output logic OSC_ENABLE_O,
	output logic RTC_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic CPU_RUN_O,
	output logic [1:0] CC_MASK_O,
	output logic CC_PUSH_O,
	output logic FETCH_RESET_VEC_O,
	output logic SERVICE_IRQ_O,
	output logic WDG_RESET_O,
	output logic [2:0] STATE_O
);
	hlpc_pkg::hlpc_state_e state;
	hlpc_pkg::hlpc_state_e next_state;
	logic [hlpc_pkg::CNT_W-1:0] cnt;
	logic [hlpc_pkg::CNT_W-1:0] next_cnt;
	logic [hlpc_pkg::CNT_W-1:0] wait_len;
	logic rtc_irq_enable;
	logic [2:0] option;
	logic [2:0] s1;
	logic [2:0] s2;
	logic rtc_irq;
	logic wake_irq;
	logic ext_reset;
	logic wake_latched;
	logic reset_latched;
	logic halt_exec;
	logic aw_hold;
	logic w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ============================================================
	// pin synchronisers
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			s1 <= 3'h0;
			s2 <= 3'h0;
		end else begin
			s1 <= {EXT_RESET_I, WAKE_IRQ_I, RTC_IRQ_I};
			s2 <= s1;
		end
	end
	assign rtc_irq = s2[0];
	assign wake_irq = s2[1];
	assign ext_reset = s2[2];

	function automatic logic [hlpc_pkg::CNT_W-1:0] wait_cycles(
		input logic long_sel
	);
		if (long_sel)
			wait_cycles = hlpc_pkg::CNT_W'(WAIT_LONG_CYC - 1);
		else
			wait_cycles = hlpc_pkg::CNT_W'(WAIT_SHORT_CYC - 1);
	endfunction

	assign wait_len = wait_cycles(option[hlpc_pkg::OPT_LONG]);
	assign halt_exec = OPCODE_VALID_I &&
		OPCODE_I == hlpc_pkg::HALT_OPCODE;

	// ============================================================
	// held wake and reset requests
	// the wake pin level reaches the latch through the two-flop synchroniser
	// on CLK_SYS_I; the latch holds it across the oscillator restart
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			wake_latched <= 1'b0;
		end else if (wake_irq && state != hlpc_pkg::ST_RUN) begin
			wake_latched <= 1'b1;
		end else if (state == hlpc_pkg::ST_RUN) begin
			wake_latched <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			reset_latched <= 1'b0;
		end else if (ext_reset && state != hlpc_pkg::ST_RUN) begin
			reset_latched <= 1'b1;
		end else if (state == hlpc_pkg::ST_RUN) begin
			reset_latched <= 1'b0;
		end
	end

	// ============================================================
	// state machine
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			hlpc_pkg::ST_RUN: begin
				if (ext_reset) begin
					next_state = hlpc_pkg::ST_RESET_WAIT;
					next_cnt = wait_len;
				end else if (halt_exec && rtc_irq_enable) begin
					next_state = hlpc_pkg::ST_ACTIVE_HALT;
				end else if (halt_exec) begin
					next_state = hlpc_pkg::ST_HALT;
				end
			end
			hlpc_pkg::ST_ACTIVE_HALT: begin
				if (ext_reset) begin
					next_state = hlpc_pkg::ST_RESET_WAIT;
					next_cnt = wait_len;
				end else if (rtc_irq || wake_irq) begin
					next_state = hlpc_pkg::ST_RUN;
					next_cnt = wait_len;
				end
			end
			hlpc_pkg::ST_HALT: begin
				if (ext_reset || wake_irq) begin
					next_state = hlpc_pkg::ST_STABILIZE;
					next_cnt = wait_len;
				end
			end
			hlpc_pkg::ST_STABILIZE, hlpc_pkg::ST_RESET_WAIT: begin
				if (cnt == '0) begin
					next_state = hlpc_pkg::ST_RUN;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = hlpc_pkg::ST_RUN;
			end
		endcase
		// post-wake window: dropping rtc enable falls into stabilize for the rest of the count
		if (state == hlpc_pkg::ST_RUN && cnt != '0 && !ext_reset &&
			!halt_exec) begin
			next_cnt = cnt - 1'b1;
			if (!rtc_irq_enable) begin
				next_state = hlpc_pkg::ST_STABILIZE;
				next_cnt = cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state <= hlpc_pkg::ST_RUN;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// ============================================================
	// clock gating and cpu control
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			OSC_ENABLE_O <= 1'b1;
			RTC_CLK_EN_O <= 1'b1;
			PERIPH_CLK_EN_O <= 1'b1;
			CPU_RUN_O <= 1'b1;
			STATE_O <= 3'h0;
		end else begin
			OSC_ENABLE_O <= next_state != hlpc_pkg::ST_HALT;
			RTC_CLK_EN_O <= next_state == hlpc_pkg::ST_RUN ||
				next_state == hlpc_pkg::ST_ACTIVE_HALT;
			PERIPH_CLK_EN_O <= next_state == hlpc_pkg::ST_RUN;
			CPU_RUN_O <= next_state == hlpc_pkg::ST_RUN;
			STATE_O <= next_state;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			CC_MASK_O <= hlpc_pkg::MASK_RESET;
			CC_PUSH_O <= 1'b0;
			SERVICE_IRQ_O <= 1'b0;
			FETCH_RESET_VEC_O <= 1'b0;
		end else begin
			CC_PUSH_O <= 1'b0;
			SERVICE_IRQ_O <= 1'b0;
			FETCH_RESET_VEC_O <= 1'b0;
			if (state == hlpc_pkg::ST_RUN && next_state != state &&
				next_state != hlpc_pkg::ST_RESET_WAIT) begin
				CC_MASK_O <= hlpc_pkg::MASK_ENABLE_ALL;
			end else if (SERVICE_I) begin
				CC_PUSH_O <= 1'b1;
				CC_MASK_O <= ISR_LEVEL_I;
			end else if (CC_POP_I) begin
				CC_MASK_O <= CC_POP_MASK_I;
			end
			if (next_state == hlpc_pkg::ST_RUN && state != next_state) begin
				if (state == hlpc_pkg::ST_RESET_WAIT || reset_latched) begin
					FETCH_RESET_VEC_O <= 1'b1;
					CC_MASK_O <= hlpc_pkg::MASK_RESET;
				end else if (state == hlpc_pkg::ST_ACTIVE_HALT ||
					wake_latched) begin
					// a return after the rtc-enable drop has no new
					// request: its interrupt was already serviced
					SERVICE_IRQ_O <= 1'b1;
				end
			end
		end
	end

	// ============================================================
	// watchdog gating
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			WDG_RESET_O <= 1'b0;
		end else if (state == hlpc_pkg::ST_ACTIVE_HALT) begin
			WDG_RESET_O <= 1'b0;
		end else if (state == hlpc_pkg::ST_HALT) begin
			WDG_RESET_O <= WDG_ENABLED_I && WDG_EXPIRE_I &&
				option[hlpc_pkg::OPT_WDG_HALT];
		end else begin
			WDG_RESET_O <= WDG_ENABLED_I && WDG_EXPIRE_I;
		end
	end

	// ============================================================
	// axi4-lite write
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			BVALID_O <= 1'b0;
			BRESP_O <= hlpc_pkg::RESP_OKAY;
			rtc_irq_enable <= 1'b0;
			option <= hlpc_pkg::OPTION_RESET;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				aw_hold <= 1'b1;
				aw_addr <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O) begin
				w_hold <= 1'b1;
				w_data <= WDATA_I;
				w_strb <= WSTRB_I;
			end
			if (aw_hold && w_hold && !BVALID_O) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O <= hlpc_pkg::RESP_OKAY;
				if (aw_addr == hlpc_pkg::ADDR_CTRL) begin
					if (w_strb[0])
						rtc_irq_enable <= w_data[hlpc_pkg::CTRL_RTC_IE];
				end else if (aw_addr == hlpc_pkg::ADDR_OPTION) begin
					if (w_strb[0])
						option <= w_data[2:0];
				end else if (aw_addr != hlpc_pkg::ADDR_STATUS) begin
					BRESP_O <= hlpc_pkg::RESP_SLVERR;
				end
			end else if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end
	assign AWREADY_O = !aw_hold && !BVALID_O;
	assign WREADY_O = !w_hold && !BVALID_O;

	// ============================================================
	// axi4-lite read
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0000_0000;
			RRESP_O <= hlpc_pkg::RESP_OKAY;
		end else if (ARVALID_I && ARREADY_O) begin
			RVALID_O <= 1'b1;
			RRESP_O <= hlpc_pkg::RESP_OKAY;
			RDATA_O <= 32'h0000_0000;
			if (ARADDR_I == hlpc_pkg::ADDR_CTRL) begin
				RDATA_O <= {31'h0, rtc_irq_enable};
			end else if (ARADDR_I == hlpc_pkg::ADDR_STATUS) begin
				// count in [15:3], state in [2:0]
				RDATA_O <= {16'h0, cnt, state};
			end else if (ARADDR_I == hlpc_pkg::ADDR_OPTION) begin
				RDATA_O <= {29'h0, option};
			end else begin
				RRESP_O <= hlpc_pkg::RESP_SLVERR;
			end
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end
	assign ARREADY_O = !RVALID_O;
endmodule // hlpc_top

// ==== tb/hlpc_cpu_model.sv ====
`timescale 1ns/1ps
// ============================================================
// cpu core: enters routine on wake, returns shortly after
module hlpc_cpu_model (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic SERVICE_IRQ_O,
	output logic SERVICE_I,
	output logic [1:0] ISR_LEVEL_I,
	output logic CC_POP_I,
	output logic [1:0] CC_POP_MASK_I
);
	logic [2:0] isr;
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I)
			isr <= 3'h0;
		else
			isr <= {isr[1:0], SERVICE_IRQ_O};
	end
	assign SERVICE_I = isr[0];
	assign ISR_LEVEL_I = isr[0] ? 2'h1 : 2'h3;
	assign CC_POP_I = isr[2];
	assign CC_POP_MASK_I = isr[2] ? 2'h2 : 2'h1;
endmodule // hlpc_cpu_model

// ==== tb/hlpc_properties.sv ====
`timescale 1ns/1ps
// ============================================================
// halt sequencing checks
module hlpc_properties (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic OPCODE_VALID_I,
	input wire logic [7:0] OPCODE_I,
	input wire logic SERVICE_I,
	input wire logic [1:0] ISR_LEVEL_I,
	input wire logic CC_POP_I,
	input wire logic [1:0] CC_POP_MASK_I,
	input wire logic WAKE_IRQ_I,
	input wire logic EXT_RESET_I,
	input wire logic OSC_ENABLE_O,
	input wire logic RTC_CLK_EN_O,
	input wire logic PERIPH_CLK_EN_O,
	input wire logic CPU_RUN_O,
	input wire logic [1:0] CC_MASK_O,
	input wire logic CC_PUSH_O,
	input wire logic FETCH_RESET_VEC_O,
	input wire logic SERVICE_IRQ_O,
	input wire logic WDG_RESET_O,
	input wire logic [2:0] STATE_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	sequence left_active_s;
		STATE_O == 3'h1 ##1 STATE_O != 3'h1;
	endsequence
	sequence quiet_halt_s;
		(STATE_O == 3'h2 && !WAKE_IRQ_I && !EXT_RESET_I)[*3];
	endsequence
	halt_entry_a: assert property (OPCODE_VALID_I &&
		OPCODE_I == hlpc_pkg::HALT_OPCODE && STATE_O == 3'h0
		|=> STATE_O inside {3'h1, 3'h2}) else $error("halt not entered");
	mask_force_a: assert property (STATE_O inside {3'h1, 3'h2} &&
		$past(STATE_O) == 3'h0 |-> CC_MASK_O == 2'h2)
		else $error("mask not forced");
	halt_clocks_a: assert property (STATE_O == 3'h2 |->
		!OSC_ENABLE_O && !PERIPH_CLK_EN_O && !CPU_RUN_O)
		else $error("clocks run in halt");
	active_clocks_a: assert property (STATE_O == 3'h1 |->
		OSC_ENABLE_O && RTC_CLK_EN_O && !PERIPH_CLK_EN_O)
		else $error("active clocks wrong");
	wdg_quiet_a: assert property (STATE_O == 3'h1 &&
		$past(STATE_O) == 3'h1 |-> !WDG_RESET_O) else $error("wdg reset");
	halt_stays_a: assert property (quiet_halt_s |=> STATE_O == 3'h2)
		else $error("halt left without cause");
	active_exit_a: assert property (left_active_s |->
		(STATE_O == 3'h0 && SERVICE_IRQ_O) || STATE_O == 3'h4)
		else $error("bad active exit");
	stab_osc_a: assert property (STATE_O inside {3'h3, 3'h4} |->
		OSC_ENABLE_O && !CPU_RUN_O) else $error("stabilize wrong");
	reset_vec_a: assert property (STATE_O == 3'h4 ##1 STATE_O == 3'h0
		|-> FETCH_RESET_VEC_O && CC_MASK_O == 2'h3)
		else $error("no vector fetch");
	cc_push_a: assert property (SERVICE_I |=> CC_PUSH_O &&
		CC_MASK_O == $past(ISR_LEVEL_I)) else $error("no push");
	cc_pop_a: assert property (CC_POP_I |=>
		CC_MASK_O == $past(CC_POP_MASK_I)) else $error("no restore");
endmodule // hlpc_properties

bind hlpc_top hlpc_properties hlpc_properties_i (.*);

// ==== tb/test_halt_low_power_control.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t: got %0h want %0h", $time, a, b); end end
module test_halt_low_power_control;
	localparam int SH = 4;
	localparam int LG = 8;
	logic CLK_SYS_I = 1'h0, RST_I = 1'h1, OPCODE_VALID_I = 1'h0;
	logic RTC_IRQ_I = 1'h0, WAKE_IRQ_I = 1'h0, EXT_RESET_I = 1'h0;
	logic WDG_ENABLED_I = 1'h1, WDG_EXPIRE_I = 1'h0, AWVALID_I = 1'h0;
	logic WVALID_I = 1'h0, BREADY_I = 1'h0, ARVALID_I = 1'h0, RREADY_I = 1'h0;
	logic [7:0] OPCODE_I = 8'h0, AWADDR_I = 8'h0, ARADDR_I = 8'h0;
	logic [31:0] WDATA_I = 32'h0, RDATA_O;
	logic [3:0] WSTRB_I = 4'hF;
	logic SERVICE_I, CC_POP_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O;
	logic [1:0] ISR_LEVEL_I, CC_POP_MASK_I, BRESP_O, RRESP_O, CC_MASK_O;
	logic RVALID_O, OSC_ENABLE_O, RTC_CLK_EN_O, PERIPH_CLK_EN_O, CPU_RUN_O;
	logic CC_PUSH_O, FETCH_RESET_VEC_O, SERVICE_IRQ_O, WDG_RESET_O;
	logic [2:0] STATE_O;
	int errors = 0, num_checks = 0;
	hlpc_top #(.WAIT_SHORT_CYC(SH), .WAIT_LONG_CYC(LG)) hlpc_top_i (.*);
	hlpc_cpu_model hlpc_cpu_model_i (.*);
	always #12.5 CLK_SYS_I = ~CLK_SYS_I;
	// ============================================================
	// bus and wait helpers
	task stop_test;
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CLK_SYS_I);
	endtask
	task wst(input logic [2:0] s);
		for (int i = 0; i < 300 && STATE_O !== s; i++) cyc(1);
		`CHK(STATE_O, s)
		if (STATE_O !== s) stop_test();
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		cyc(1);
		AWADDR_I <= a;
		WDATA_I <= d;
		AWVALID_I <= 1'h1;
		WVALID_I <= 1'h1;
		BREADY_I <= 1'h1;
		for (int i = 0; i < 50 && BVALID_O !== 1'h1; i++) begin
			cyc(1);
			if (AWREADY_O) AWVALID_I <= 1'h0;
			if (WREADY_O) WVALID_I <= 1'h0;
		end
		BREADY_I <= 1'h0;
		`CHK(BRESP_O, r)
		if (BVALID_O !== 1'h1) begin
			errors++;
			stop_test();
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		cyc(1);
		ARADDR_I <= a;
		ARVALID_I <= 1'h1;
		RREADY_I <= 1'h1;
		for (int i = 0; i < 50 && RVALID_O !== 1'h1; i++) begin
			cyc(1);
			if (ARREADY_O) ARVALID_I <= 1'h0;
		end
		RREADY_I <= 1'h0;
		`CHK({RRESP_O, RDATA_O}, {r, d})
		if (RVALID_O !== 1'h1) begin
			errors++;
			stop_test();
		end
	endtask
	task op(input logic [7:0] c);
		OPCODE_I <= c;
		OPCODE_VALID_I <= 1'h1;
		cyc(1);
		OPCODE_VALID_I <= 1'h0;
		cyc(1);
	endtask
	// ============================================================
	// scenarios
	task t_regs;
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		wr(8'h0C, 32'h1, 2'h2);
		rd(8'h0C, 32'h0, 2'h2);
		WDG_EXPIRE_I <= 1'h1;
		op(8'h8D);
		`CHK(STATE_O, 3'h0)
		`CHK(WDG_RESET_O, 1'h1)
		WDG_EXPIRE_I <= 1'h0;
	endtask
	task t_halt;
		int n;
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, 32'h0, 2'h0);
			wr(8'h08, k ? 32'h3 : 32'h0, 2'h0);
			op(8'h8E);
			`CHK(STATE_O, 3'h2)
			`CHK({OSC_ENABLE_O, PERIPH_CLK_EN_O, CC_MASK_O}, 4'h2)
			RTC_IRQ_I <= 1'h1;
			WDG_EXPIRE_I <= 1'h1;
			cyc(6);
			`CHK(WDG_RESET_O, k[0])
			RTC_IRQ_I <= 1'h0;
			WDG_EXPIRE_I <= 1'h0;
			`CHK(STATE_O, 3'h2)
			WAKE_IRQ_I <= 1'h1;
			wst(3'h3);
			WAKE_IRQ_I <= 1'h0;
			for (n = 0; n < 20 && STATE_O === 3'h3; n++) cyc(1);
			`CHK(n, k ? LG : SH)
			`CHK(SERVICE_IRQ_O, 1'h1)
		end
	endtask
	task t_active;
		wr(8'h00, 32'h1, 2'h0);
		op(8'h8E);
		`CHK(STATE_O, 3'h1)
		`CHK({OSC_ENABLE_O, RTC_CLK_EN_O, PERIPH_CLK_EN_O}, 3'h6)
		WDG_EXPIRE_I <= 1'h1;
		cyc(4);
		`CHK(WDG_RESET_O, 1'h0)
		WDG_EXPIRE_I <= 1'h0;
		RTC_IRQ_I <= 1'h1;
		wst(3'h0);
		`CHK(SERVICE_IRQ_O, 1'h1)
		RTC_IRQ_I <= 1'h0;
		wr(8'h00, 32'h0, 2'h0);
		wst(3'h3);
		wst(3'h0);
	endtask
	task t_reset;
		int n;
		wr(8'h00, 32'h1, 2'h0);
		op(8'h8E);
		EXT_RESET_I <= 1'h1;
		wst(3'h4);
		EXT_RESET_I <= 1'h0;
		for (n = 0; n < 20 && STATE_O === 3'h4; n++) cyc(1);
		`CHK(n, LG)
		wst(3'h0);
		`CHK({FETCH_RESET_VEC_O, CC_MASK_O}, 3'h7)
	endtask
	initial begin
		cyc(5);
		RST_I <= 1'h0;
		t_regs();
		t_halt();
		t_active();
		t_reset();
		stop_test();
	end
endmodule // test_halt_low_power_control
